// ---- ipf_map.vh ----
// Constants for the idle power feature settings block.
// Assumes a 100 MHz system clock and a command port driven by the admin command logic.
`ifndef IPF_MAP_VH
`define IPF_MAP_VH
`define IPF_FID_APST 8'h0C
`define IPF_FID_LOAD 8'h80
`define IPF_FID_HOST 8'h81
`define IPF_APST_EN_BIT 0
`define IPF_APST_EN_RST 1'h0
`define IPF_LOAD_RST 8'h00
`define IPF_HOST_RST 64'h0000000000000000
`define IPF_TABLE_BYTES 256
`define IPF_TABLE_ENTRIES 32
`define IPF_ENTRY_BYTES 8
`define IPF_IDLE_TIME_BEFORE_TRANSITION_LSB 8
`define IPF_IDLE_TIME_BEFORE_TRANSITION_MSB 31
`define IPF_IDLE_TARGET_POWER_STATE_LSB 3
`define IPF_IDLE_TARGET_POWER_STATE_MSB 7
`define IPF_CLK_MHZ 100
`define IPF_MS_NS 1000000
`define IPF_CLK_NS 10
`define IPF_CYC_PER_MS (`IPF_MS_NS / `IPF_CLK_NS)
`define IPF_REG_APST 4'h0
`define IPF_REG_LOAD 4'h1
`define IPF_REG_HOSTLO 4'h2
`define IPF_REG_HOSTHI 4'h3
`define IPF_REG_PSTATE 4'h4
`define IPF_REG_HOSTMATCH 4'h5
`endif

// ---- ipf_idle_timer.v ----
// Idle timer: counts whole milliseconds of uninterrupted idleness.
// Assumes restart and the limit come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ipf_idle_timer #(
  parameter MS_CYCLES = 100000
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire restart_i,
  input wire [23:0] limit_ms_i,
  output reg expired_o
);
  // Cycle counter inside one millisecond.
  reg [16:0] cyc;
  // Whole milliseconds of idleness seen so far.
  reg [23:0] ms;

  // Any restart clears both counters, so only continuous idleness counts.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i || restart_i) begin
      cyc <= 17'h00000;
      ms <= 24'h000000;
      expired_o <= 1'b0;
    end else begin
      if (cyc == MS_CYCLES[16:0] - 17'h00001) begin
        cyc <= 17'h00000;
        if (ms != 24'hFFFFFF) begin
          ms <= ms + 24'h000001;
        end
      end else begin
        cyc <= cyc + 17'h00001;
      end
      // Strictly greater: the idle time must exceed the limit. A zero limit never fires.
      expired_o <= (limit_ms_i != 24'h000000) && (ms > limit_ms_i);
    end
  end
endmodule // ipf_idle_timer
`default_nettype wire

// ---- ipf_feature_settings.v ----
// Feature settings handler: set/get of autonomous power transition, load marker, host id.
// Assumes the command logic presents one command at a time on the same clock.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "ipf_map.vh"
module ipf_feature_settings #(
  parameter MS_CYCLES = `IPF_CYC_PER_MS
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  // Command port: one-cycle strobe with feature id and command parameter word.
  input wire cmd_valid_i,
  input wire cmd_set_i,
  input wire [7:0] cmd_fid_i,
  input wire [31:0] cmd_param_i,
  // Data buffer port, one byte per cycle, byte offset from the buffer start.
  input wire buf_wr_i,
  input wire [7:0] buf_addr_i,
  input wire [7:0] buf_wdata_i,
  input wire buf_rd_i,
  output reg [7:0] buf_rdata_o,
  // Completion of a command.
  output reg cpl_valid_o,
  output reg cpl_ok_o,
  output reg [31:0] cpl_dw0_o,
  // Outstanding work elsewhere in the controller; comes from a pin.
  input wire work_pending_i,
  // Identity of a peer controller for reservation grouping.
  input wire [63:0] peer_identity_i,
  output reg same_host_o,
  output reg [4:0] power_state_o,
  output reg auto_power_transition_enable_o,
  output reg [63:0] host_identity_value_o,
  // Register port.
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o
);
  // Transition table: 256 bytes, entry n at bytes 8n+7..8n.
  reg [7:0] apst_table [0:`IPF_TABLE_BYTES-1];
  // Enable bit, load marker and host identity.
  reg auto_power_transition_enable;
  reg [7:0] preboot_load_count;
  reg [63:0] host_identity_value;
  // Current power state.
  reg [4:0] power_state;
  // Synchroniser for the pending-work pin.
  reg work_meta;
  reg work_sync;
  // Which buffer the data port addresses: table or host identity.
  reg buf_sel_host;
  // Fields of the current state's entry.
  wire [23:0] idle_time_before_transition;
  wire [4:0] idle_target_power_state;
  // Low byte of the current entry; the target sits in its upper five bits.
  wire [7:0] entry_low_byte;
  // Holds one cycle after a transition so the timer starts fresh in the new state.
  // It is declared here because the timer instance below reads it.
  reg idle_expired_q;
  wire idle_expired;
  wire idle_restart;
  integer i;

  // Returns byte k of entry st.
  function [7:0] tbl_byte;
    input [4:0] st;
    input [2:0] k;
    begin
      tbl_byte = apst_table[{st, k}];
    end
  endfunction

  // Decodes whether a feature id is one this block owns.
  function fid_known;
    input [7:0] fid;
    begin
      fid_known = (fid == `IPF_FID_APST) || (fid == `IPF_FID_LOAD) ||
                  (fid == `IPF_FID_HOST);
    end
  endfunction

  // Idle time from bits 31:8 and target from bits 7:3 of the current entry.
  assign idle_time_before_transition = {tbl_byte(power_state, 3'h3),
    tbl_byte(power_state, 3'h2), tbl_byte(power_state, 3'h1)};
  assign entry_low_byte = tbl_byte(power_state, 3'h0);
  // Taking a part-select keeps the width explicit instead of a truncating shift.
  assign idle_target_power_state = entry_low_byte[`IPF_IDLE_TARGET_POWER_STATE_MSB:`IPF_IDLE_TARGET_POWER_STATE_LSB];

  // Idle is broken by any command, buffer traffic or pending work.
  assign idle_restart = cmd_valid_i || buf_wr_i || buf_rd_i || work_sync ||
                        !auto_power_transition_enable;

  // The timer restarts on each state change as well, via the restart term below.
  ipf_idle_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .restart_i(idle_restart || idle_expired_q),
    .limit_ms_i(idle_time_before_transition),
    .expired_o(idle_expired)
  );

  // Two flip-flops on the pin before anything reads it.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      work_meta <= 1'b0;
      work_sync <= 1'b0;
    end else begin
      work_meta <= work_pending_i;
      work_sync <= work_meta;
    end
  end

  // Autonomous move to the target state once idleness exceeds the limit.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      power_state <= 5'h00;
      idle_expired_q <= 1'b0;
    end else begin
      idle_expired_q <= idle_expired && !idle_expired_q;
      if (idle_expired && !idle_expired_q && !idle_restart) begin
        power_state <= idle_target_power_state;
      end else if (cmd_valid_i || work_sync) begin
        // A command or pending work returns the controller to the operational state 0; buffer traffic does not.
        power_state <= 5'h00;
      end
    end
  end

  // Set and get processing; completion one cycle after the command strobe.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      auto_power_transition_enable <= `IPF_APST_EN_RST;
      preboot_load_count <= `IPF_LOAD_RST;
      cpl_valid_o <= 1'b0;
      cpl_ok_o <= 1'b0;
      cpl_dw0_o <= 32'h00000000;
      buf_sel_host <= 1'b0;
    end else begin
      cpl_valid_o <= cmd_valid_i;
      if (cmd_valid_i) begin
        cpl_ok_o <= fid_known(cmd_fid_i);
        // Reserved dword bits are forced to zero.
        cpl_dw0_o <= 32'h00000000;
        buf_sel_host <= (cmd_fid_i == `IPF_FID_HOST);
        case (cmd_fid_i)
          `IPF_FID_APST: begin
            if (cmd_set_i) begin
              auto_power_transition_enable <= cmd_param_i[`IPF_APST_EN_BIT];
            end else begin
              cpl_dw0_o <= {31'h00000000, auto_power_transition_enable};
            end
          end
          `IPF_FID_LOAD: begin
            // Stored as written; saturation and clearing are software's job.
            if (cmd_set_i) begin
              preboot_load_count <= cmd_param_i[7:0];
            end else begin
              cpl_dw0_o <= {24'h000000, preboot_load_count};
            end
          end
          default: begin
            // Host identity travels in the buffer; unknown ids complete with failure.
          end
        endcase
      end else begin
        cpl_ok_o <= 1'b0;
      end
      if (reg_wr_i && reg_addr_i == `IPF_REG_APST) begin
        auto_power_transition_enable <= reg_wdata_i[0];
      end
      if (reg_wr_i && reg_addr_i == `IPF_REG_LOAD) begin
        preboot_load_count <= reg_wdata_i[7:0];
      end
    end
  end

  // The load marker never depends on power_state, so it survives transitions.

  // Buffer writes fill the table or the identity; reads return them.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      host_identity_value <= `IPF_HOST_RST;
      buf_rdata_o <= 8'h00;
      for (i = 0; i < `IPF_TABLE_BYTES; i = i + 1) begin
        apst_table[i] <= 8'h00;
      end
    end else begin
      if (buf_wr_i) begin
        if (buf_sel_host) begin
          if (buf_addr_i < 8'h08) begin
            // Accepted at any time; the registered match output follows one cycle after the stored byte.
            host_identity_value[{buf_addr_i[2:0], 3'h0} +: 8] <= buf_wdata_i;
          end
        end else if (buf_addr_i[2:0] == 3'h0) begin
          // Reserved bits 2:0 are stored as zero.
          apst_table[buf_addr_i] <= buf_wdata_i & 8'hF8;
        end else if (buf_addr_i[2]) begin
          // Bytes 4..7 of each entry are reserved.
          apst_table[buf_addr_i] <= 8'h00;
        end else begin
          apst_table[buf_addr_i] <= buf_wdata_i;
        end
      end
      if (reg_wr_i && reg_addr_i == `IPF_REG_HOSTLO) begin
        host_identity_value[31:0] <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `IPF_REG_HOSTHI) begin
        host_identity_value[63:32] <= reg_wdata_i;
      end
      if (buf_rd_i) begin
        if (buf_sel_host) begin
          buf_rdata_o <= (buf_addr_i < 8'h08) ?
            host_identity_value[{buf_addr_i[2:0], 3'h0} +: 8] : 8'h00;
        end else begin
          buf_rdata_o <= apst_table[buf_addr_i];
        end
      end
    end
  end

  // Reservation grouping and mirrored outputs.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      same_host_o <= 1'b0;
      power_state_o <= 5'h00;
      auto_power_transition_enable_o <= 1'b0;
      host_identity_value_o <= 64'h0000000000000000;
    end else begin
      // Zero never groups; equal nonzero identities share rights.
      same_host_o <= (host_identity_value != 64'h0000000000000000) &&
                     (host_identity_value == peer_identity_i);
      power_state_o <= power_state;
      auto_power_transition_enable_o <= auto_power_transition_enable;
      host_identity_value_o <= host_identity_value;
    end
  end

  // Register reads: data stand the cycle after the strobe only.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `IPF_REG_APST: reg_rdata_o <= {31'h00000000, auto_power_transition_enable};
        `IPF_REG_LOAD: reg_rdata_o <= {24'h000000, preboot_load_count};
        `IPF_REG_HOSTLO: reg_rdata_o <= host_identity_value[31:0];
        `IPF_REG_HOSTHI: reg_rdata_o <= host_identity_value[63:32];
        `IPF_REG_PSTATE: reg_rdata_o <= {27'h0000000, power_state};
        `IPF_REG_HOSTMATCH: reg_rdata_o <= {31'h00000000, same_host_o};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end
endmodule // ipf_feature_settings
`default_nettype wire

// ---- ipf_host_buf.sv ----
// Host side data buffer that holds the image of the power transition table.
// Assumes the bench indexes it by byte offset and copies each byte to the block.
`timescale 1ns/1ns
`default_nettype none
module ipf_host_buf (
  input wire logic [7:0] idx_i,
  output logic [7:0] byte_o
);
  // Only entry 0 is live: target state 3, idle 2 ms. Every other entry is zero.
  // Reserved bits are deliberately dirty so the bench can see that they are dropped.
  always_comb begin
    case (idx_i)
      8'h00: byte_o = 8'h1F;
      8'h01: byte_o = 8'h02;
      8'h04: byte_o = 8'hAA; // Reserved upper half.
      default: byte_o = 8'h00;
    endcase
  end
endmodule // ipf_host_buf
`default_nettype wire

// ---- ipf_fs_sva.sv ----
// Checker for the ports of the feature settings block.
// Assumes it is bound to ipf_feature_settings on one clock.
`timescale 1ns/1ns
`default_nettype none
module ipf_fs_sva (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire cmd_valid_i,
  input wire cmd_set_i,
  input wire [7:0] cmd_fid_i,
  input wire [31:0] cmd_param_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire work_pending_i,
  input wire [63:0] peer_identity_i,
  input wire cpl_valid_o,
  input wire cpl_ok_o,
  input wire [31:0] cpl_dw0_o,
  input wire same_host_o,
  input wire [4:0] power_state_o,
  input wire auto_power_transition_enable_o,
  input wire [63:0] host_identity_value_o,
  input wire [31:0] reg_rdata_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // High when the command names one of the three handled features.
  wire known_fid = cmd_fid_i == 8'h0C || cmd_fid_i == 8'h80 || cmd_fid_i == 8'h81;
  // A get command for one feature.
  sequence get_s(fid);
    cmd_valid_i && !cmd_set_i && cmd_fid_i == fid;
  endsequence
  // Identity held at zero long enough for the compare register to settle.
  sequence id_zero_s;
    (host_identity_value_o == 64'h0) [*3];
  endsequence
  sequence id_match_s;
    (host_identity_value_o != 64'h0 && peer_identity_i == host_identity_value_o) [*3];
  endsequence
  cpl_pulse_a: assert property (cmd_valid_i |=> cpl_valid_o) else $error("no completion");
  cpl_quiet_a: assert property (!cmd_valid_i |=> !cpl_valid_o) else $error("stray completion");
  fid_ok_a: assert property (cmd_valid_i |=> cpl_ok_o == $past(known_fid))
    else $error("completion status wrong");
  en_set_a: assert property (cmd_valid_i && cmd_set_i && cmd_fid_i == 8'h0C && !reg_wr_i
    |=> ##1 auto_power_transition_enable_o == $past(cmd_param_i[0], 2)) else $error("enable not set");
  en_get_a: assert property (get_s(8'h0C)
    |=> cpl_dw0_o == {31'h0, $past(auto_power_transition_enable_o)}) else $error("enable get");
  load_get_a: assert property (get_s(8'h80) |=> cpl_dw0_o[31:8] == 24'h0)
    else $error("load count upper bits");
  id_zero_a: assert property (id_zero_s |-> !same_host_o) else $error("zero id grouped");
  id_match_a: assert property (id_match_s |-> same_host_o) else $error("match missed");
  work_wake_a: assert property (work_pending_i [*3] |-> ##[1:3] power_state_o == 5'h0)
    else $error("pending work did not wake");
  auto_only_a: assert property (power_state_o != $past(power_state_o) && power_state_o != 5'h0
    |-> $past(auto_power_transition_enable_o)) else $error("move while disabled");
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data leak");
endmodule // ipf_fs_sva
bind ipf_feature_settings ipf_fs_sva chk_u (.sys_clk_i, .reset_n_i, .cmd_valid_i, .cmd_set_i,
  .cmd_fid_i, .cmd_param_i, .reg_wr_i, .reg_rd_i, .work_pending_i, .peer_identity_i,
  .cpl_valid_o, .cpl_ok_o, .cpl_dw0_o, .same_host_o, .power_state_o,
  .auto_power_transition_enable_o, .host_identity_value_o, .reg_rdata_o);
`default_nettype wire

// ---- idle_power_feature_settings_tb.sv ----
// Testbench for the feature settings block: commands, buffer and register traffic.
// Assumes a 100 MHz clock and a millisecond shortened to 10 cycles.
`timescale 1ns/1ns
`default_nettype none
module idle_power_feature_settings_tb;
  logic sys_clk_i, reset_n_i, cmd_valid_i, cmd_set_i, buf_wr_i, buf_rd_i, work_pending_i;
  logic reg_wr_i, reg_rd_i, cpl_valid_o, cpl_ok_o, same_host_o, auto_power_transition_enable_o;
  logic [7:0] cmd_fid_i, buf_addr_i, buf_wdata_i, buf_rdata_o, host_idx, host_byte, exp8;
  logic [31:0] cmd_param_i, cpl_dw0_o, reg_wdata_i, reg_rdata_o;
  logic [63:0] peer_identity_i, host_identity_value_o;
  logic [3:0] reg_addr_i;
  logic [4:0] power_state_o;
  int mismatches = 0, check_count = 0, cycles = 0, n;
  ipf_feature_settings #(.MS_CYCLES(10)) dut_u (.sys_clk_i, .reset_n_i, .cmd_valid_i,
    .cmd_set_i, .cmd_fid_i, .cmd_param_i, .buf_wr_i, .buf_addr_i, .buf_wdata_i, .buf_rd_i,
    .buf_rdata_o, .cpl_valid_o, .cpl_ok_o, .cpl_dw0_o, .work_pending_i, .peer_identity_i,
    .same_host_o, .power_state_o, .auto_power_transition_enable_o, .host_identity_value_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  ipf_host_buf host_u (.idx_i(host_idx), .byte_o(host_byte));
  // Free running clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard; the whole run needs roughly 1300 cycles.
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One command cycle; completion is looked at in the cycle where it stands.
  task automatic cmd(input logic wr, input logic [7:0] fid, input logic [31:0] prm);
    @(posedge sys_clk_i);
    {cmd_valid_i, cmd_set_i, cmd_fid_i, cmd_param_i} <= {1'b1, wr, fid, prm};
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask
  // Kind 0 register write, 1 register read, 2 buffer write, 3 buffer read.
  task automatic bus(input logic [1:0] kind, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    {reg_wr_i, reg_rd_i, buf_wr_i, buf_rd_i} <= {kind == 0, kind == 1, kind == 2, kind == 3};
    {reg_addr_i, buf_addr_i, reg_wdata_i, buf_wdata_i} <= {a[3:0], a, d, d[7:0]};
    @(posedge sys_clk_i);
    {reg_wr_i, reg_rd_i, buf_wr_i, buf_rd_i} <= 4'h0;
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {cmd_valid_i, cmd_set_i, buf_wr_i, buf_rd_i, reg_wr_i, reg_rd_i, work_pending_i} = 7'h00;
    {cmd_fid_i, cmd_param_i, buf_addr_i, buf_wdata_i, reg_addr_i, reg_wdata_i} = 92'h0;
    {reset_n_i, peer_identity_i, host_idx} = 73'h0;
    repeat (5) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    bus(1, 8'h00, 0);
    check("enable reg", reg_rdata_o, 0);
    cmd(0, 8'h0C, 0);
    check("enable default", cpl_dw0_o, 0);
    cmd(1, 8'h80, 32'hFFFFFF05);
    cmd(1, 8'h0B, 1);
    check("unknown fid", cpl_ok_o, 0);
    cmd(1, 8'h0C, 32'hFFFFFFFF);
    check("known fid", cpl_ok_o, 1);
    cmd(0, 8'h0C, 0);
    check("enable get", cpl_dw0_o, 1);
    bus(1, 8'h0F, 0);
    check("unmapped reg", reg_rdata_o, 0);
    // Load the whole table, then read it back under a get.
    for (n = 0; n < 256; n++) begin
      host_idx = n[7:0];
      #1;
      bus(2, n[7:0], {24'h0, host_byte});
    end
    cmd(0, 8'h0C, 0);
    for (n = 0; n < 256; n++) begin
      host_idx = n[7:0];
      bus(3, n[7:0], 0);
      exp8 = (n % 8 == 0) ? host_byte & 8'hF8 : (n % 8 > 3) ? 8'h00 : host_byte;
      check("table byte", buf_rdata_o, exp8);
    end
    // Stay idle until the move to state 3; it must not come before 2 ms.
    n = 0;
    while (power_state_o !== 5'h3 && n < 80) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check("idle target", power_state_o, 3);
    check("idle exceeded", n > 20, 1);
    repeat (60) @(posedge sys_clk_i);
    #1;
    check("zero idle holds", power_state_o, 3);
    @(posedge sys_clk_i);
    work_pending_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    work_pending_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check("work wakes", power_state_o, 0);
    cmd(0, 8'h80, 0);
    check("load kept", cpl_dw0_o, 32'h05);
    cmd(1, 8'h80, 32'h000000FF);
    cmd(0, 8'h80, 0);
    check("load saturated", cpl_dw0_o, 32'hFF);
    cmd(1, 8'h80, 0);
    cmd(0, 8'h80, 0);
    check("load cleared", cpl_dw0_o, 0);
    cmd(1, 8'h0C, 0);
    repeat (60) @(posedge sys_clk_i);
    #1;
    check("disabled stays", power_state_o, 0);
    bus(0, 8'h00, 1);
    // The mirrored output lags the stored bit by one cycle.
    @(posedge sys_clk_i);
    #1;
    check("enable by reg", auto_power_transition_enable_o, 1);
    // Host identity through the buffer; byte 8 lies outside and is dropped.
    cmd(1, 8'h81, 0);
    for (n = 0; n < 9; n++) bus(2, n[7:0], (n + 1) * 17);
    check("id value", host_identity_value_o, 64'h8877665544332211);
    cmd(0, 8'h81, 0);
    for (n = 0; n < 8; n++) begin
      bus(3, n[7:0], 0);
      check("id byte", buf_rdata_o, (n + 1) * 17);
    end
    @(posedge sys_clk_i);
    peer_identity_i <= 64'h8877665544332211;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check("same host", same_host_o, 1);
    bus(0, 8'h02, 0);
    bus(0, 8'h03, 0);
    @(posedge sys_clk_i);
    #1;
    check("id remapped", host_identity_value_o, 0);
    @(posedge sys_clk_i);
    peer_identity_i <= 64'h0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check("zero id alone", same_host_o, 0);
    finish_test();
  end
endmodule // idle_power_feature_settings_tb
`default_nettype wire
